/* File: dout_pkg.sv */
// package for the eight-channel digital output stage
// assumes a single 125 MHz system clock shared by every file
package dout_pkg;
    localparam int          NUM_CHANNELS     = 8;
    localparam int          NUM_CONNECTORS   = 4;
    localparam int          CNT_WIDTH        = 32;
    localparam logic [31:0] CNT_LIMIT_RESET  = 32'h000F_4240;
    // indicator flash timing
    localparam int          CLK_FREQ_HZ      = 125_000_000;
    localparam int          FLASH_HALF_MS    = 250;
    localparam int          FLASH_HALF_CYC   = CLK_FREQ_HZ / 1000 * FLASH_HALF_MS;
    localparam int          FLASH_CNT_W      = 32;
    // register map
    localparam logic [3:0]  REG_OUT_IMAGE    = 4'h0;
    localparam logic [3:0]  REG_CNT_LIMIT    = 4'h1;
    localparam logic [3:0]  REG_STATUS       = 4'h2;
    localparam logic [3:0]  REG_MASK         = 4'h3;
    localparam logic [3:0]  REG_EXCEEDED     = 4'h4;
    localparam logic [3:0]  REG_OPEN_LOAD    = 4'h5;
    localparam logic [3:0]  REG_SHORT        = 4'h6;
    localparam logic [3:0]  REG_OL_ENABLE    = 4'h7;
    // status bit positions
    localparam int          ST_SHORT         = 0;
    localparam int          ST_EXCEEDED      = 1;
    localparam int          ST_OPEN_LOAD     = 2;
    localparam int          ST_INT_FAIL      = 3;
    localparam int          ST_WIDTH         = 4;
    // indicator states
    typedef enum logic [2:0] {
        LED_DARK       = 3'b000,
        LED_GREEN      = 3'b001,
        LED_RED        = 3'b010,
        LED_RED_FLASH  = 3'b011,
        LED_ALTERNATE  = 3'b100
    } dout_led_type;
endpackage : dout_pkg

/* File: dout_unit.sv */
// eight-channel output stage: pin routing, diagnostics, indicator, registers
// assumes load-diagnostic inputs are asynchronous pins; bus on clk
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// R01: even image bit to pin 4, odd to pin 2
// R02: eight channels, two per connector
// R03: open load checked only while output off
// R04: open-load enable only from handheld terminal
// R05: indicator dark without power or output off
// R06: steady green while output on, no fault
// R07: steady red on load short circuit
// R08: flash red on count exceeded or open load
// R09: alternate red/green on internal failure
// R10: per-channel rising-edge counter with exceeded flag
// R11: priority failure, short, flash, green, dark
module dout_unit #(
    parameter int FLASH_HALF = dout_pkg::FLASH_HALF_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic [3:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [31:0]                  reg_rdata,
    input  wire logic                         term_ol_wr,
    input  wire logic [dout_pkg::NUM_CHANNELS-1:0] term_ol_data,
    input  wire logic                         control_power,
    input  wire logic [dout_pkg::NUM_CHANNELS-1:0] short_pin,
    input  wire logic [dout_pkg::NUM_CHANNELS-1:0] open_pin,
    input  wire logic                         int_fail_pin,
    output logic      [dout_pkg::NUM_CONNECTORS-1:0] conn_pin4,
    output logic      [dout_pkg::NUM_CONNECTORS-1:0] conn_pin2,
    output logic                              led_red,
    output logic                              led_green,
    output logic                              irq
);
    import dout_pkg::*;

    logic                    rst_s1_q, rst_s2_q;
    logic                    rstn;
    logic [NUM_CHANNELS-1:0] image_q;
    logic [CNT_WIDTH-1:0]    limit_q;
    logic [NUM_CHANNELS-1:0] ol_en_q;
    logic [ST_WIDTH-1:0]     status_q, mask_q;
    logic [NUM_CHANNELS-1:0] short_s1_q, short_s2_q, open_s1_q, open_s2_q;
    logic                    fail_s1_q, fail_s2_q, pwr_s1_q, pwr_s2_q;
    logic [NUM_CHANNELS-1:0] prev_q;
    logic [NUM_CHANNELS-1:0] exceeded_q;
    logic [CNT_WIDTH-1:0]    count_q [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] open_det;
    logic [ST_WIDTH-1:0]     events;
    logic [FLASH_CNT_W-1:0]  flash_cnt_q;
    logic                    phase_q;
    dout_led_type            led_d, led_q;

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops so deassertion is clean
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rstn = rst_s2_q;

    // pin inputs pass two flops before any logic
    // short sense lines; only the second stage is read downstream
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            short_s1_q <= '0;
            short_s2_q <= '0;
        end else begin
            short_s1_q <= short_pin;
            short_s2_q <= short_s1_q;
        end
    end

    // open-load sense lines
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open_s1_q <= '0;
            open_s2_q <= '0;
        end else begin
            open_s1_q <= open_pin;
            open_s2_q <= open_s1_q;
        end
    end

    // internal failure line
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fail_s1_q <= 1'b0;
            fail_s2_q <= 1'b0;
        end else begin
            fail_s1_q <= int_fail_pin;
            fail_s2_q <= fail_s1_q;
        end
    end

    // control power sense; reads absent until two edges after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
        end else begin
            pwr_s1_q <= control_power;
            pwr_s2_q <= pwr_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output image, written from the fieldbus side
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            image_q <= '0;
        end else if (reg_wr && reg_addr == REG_OUT_IMAGE) begin
            image_q <= reg_wdata[NUM_CHANNELS-1:0];
        end
    end

    // switching count limit; takes effect on the next compare
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            limit_q <= CNT_LIMIT_RESET;
        end else if (reg_wr && reg_addr == REG_CNT_LIMIT) begin
            limit_q <= reg_wdata[CNT_WIDTH-1:0];
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= '0;
        end else if (reg_wr && reg_addr == REG_MASK) begin
            mask_q <= reg_wdata[ST_WIDTH-1:0];
        end
    end

    // open-load enable has no bus write path; terminal port only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ol_en_q <= '0;
        end else if (term_ol_wr) begin
            ol_en_q <= term_ol_data; // R04
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // connector routing: channel 2n on pin 4, 2n+1 on pin 2
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conn_pin4 <= '0;
            conn_pin2 <= '0;
        end else begin
            for (int n = 0; n < NUM_CONNECTORS; n++) begin
                conn_pin4[n] <= image_q[2*n];   // R01 R02
                conn_pin2[n] <= image_q[2*n+1]; // R01 R02
            end
        end
    end

    // a driven channel masks the sense line, which reads open when on
    assign open_det = open_s2_q & ~image_q & ol_en_q; // R03

    ////////////////////////////////////////////////////////////////////////////
    // switching counters: count off-to-on edges, flag once past limit
    // exceeded stays set until reset; lowering the limit cannot clear it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q     <= '0;
            exceeded_q <= '0;
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                count_q[i] <= '0;
            end
        end else begin
            prev_q <= image_q;
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                // saturate so a stuck flag never wraps back to clear
                if (image_q[i] && !prev_q[i] && count_q[i] != '1) begin
                    count_q[i] <= count_q[i] + 1'b1; // R10
                end
                if (count_q[i] > limit_q) begin
                    exceeded_q[i] <= 1'b1; // R10
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status; a new event wins over a write-one clear
    assign events = {fail_s2_q, |open_det, |exceeded_q, |short_s2_q};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
        end else begin
            if (reg_wr && reg_addr == REG_STATUS) begin
                status_q <= (status_q & ~reg_wdata[ST_WIDTH-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    assign irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // flash timebase shared by every blinking pattern
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flash_cnt_q <= '0;
            phase_q     <= 1'b0;
        end else if (flash_cnt_q == FLASH_CNT_W'(FLASH_HALF - 1)) begin
            flash_cnt_q <= '0;
            phase_q     <= ~phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // indicator selection by priority on live conditions
    always_comb begin
        // power loss darkens the indicator whatever else is pending
        if (!pwr_s2_q) begin
            led_d = LED_DARK; // R05
        end else if (fail_s2_q) begin
            led_d = LED_ALTERNATE; // R11 R09
        end else if (|short_s2_q) begin
            led_d = LED_RED; // R11 R07
        end else if (|exceeded_q || |open_det) begin
            led_d = LED_RED_FLASH; // R11 R08
        end else if (|image_q) begin
            led_d = LED_GREEN; // R11 R06
        end else begin
            led_d = LED_DARK; // R05
        end
    end

    // registered indicator drive, two cycles behind the selection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            led_q     <= LED_DARK;
            led_red   <= 1'b0;
            led_green <= 1'b0;
        end else begin
            led_q <= led_d;
            case (led_q)
                LED_GREEN: begin
                    led_red   <= 1'b0;
                    led_green <= 1'b1; // R06
                end
                LED_RED: begin
                    led_red   <= 1'b1; // R07
                    led_green <= 1'b0;
                end
                LED_RED_FLASH: begin
                    led_red   <= phase_q; // R08
                    led_green <= 1'b0;
                end
                LED_ALTERNATE: begin
                    led_red   <= phase_q;  // R09
                    led_green <= ~phase_q; // R09
                end
                default: begin
                    led_red   <= 1'b0; // R05
                    led_green <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == REG_OUT_IMAGE) begin
                reg_rdata <= {24'h000000, image_q};
            end else if (reg_addr == REG_CNT_LIMIT) begin
                reg_rdata <= limit_q;
            end else if (reg_addr == REG_STATUS) begin
                reg_rdata <= {28'h0000000, status_q};
            end else if (reg_addr == REG_MASK) begin
                reg_rdata <= {28'h0000000, mask_q};
            end else if (reg_addr == REG_EXCEEDED) begin
                reg_rdata <= {24'h000000, exceeded_q};
            end else if (reg_addr == REG_OPEN_LOAD) begin
                reg_rdata <= {24'h000000, open_det};
            end else if (reg_addr == REG_SHORT) begin
                reg_rdata <= {24'h000000, short_s2_q};
            end else if (reg_addr == REG_OL_ENABLE) begin
                reg_rdata <= {24'h000000, ol_en_q};
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : dout_unit

/* File: dout_unit_assertions.sv */
// checker for dout_unit: pin routing, read idle, indicator priority
// assumes it is bound onto dout_unit with a single clk domain
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dout_unit_chk
    import dout_pkg::*;
#(
    parameter int FLASH_HALF = 4
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        control_power,
    input wire logic [7:0]  short_pin,
    input wire logic        int_fail_pin,
    input wire logic [3:0]  conn_pin4,
    input wire logic [3:0]  conn_pin2,
    input wire logic        led_red,
    input wire logic        led_green
);
    logic img_wr;
    // image write strobe, shared by both routing checks
    assign img_wr = reg_wr && reg_addr == REG_OUT_IMAGE;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // pins show the image two cycles after the write is taken
    property p_pin4;
        $past(img_wr, 2) && !$past(img_wr) |->
            conn_pin4 == $past({reg_wdata[6], reg_wdata[4], reg_wdata[2], reg_wdata[0]}, 2);
    endproperty
    a_pin4: assert property (p_pin4) else $error("pin4 routing wrong");
    property p_pin2;
        $past(img_wr, 2) && !$past(img_wr) |->
            conn_pin2 == $past({reg_wdata[7], reg_wdata[5], reg_wdata[3], reg_wdata[1]}, 2);
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 routing wrong");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        reg_rd && reg_addr > 4'h7 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // sync plus indicator pipeline is four cycles, six gives margin
    property p_dark;
        (!control_power) [*6] |-> !led_red && !led_green;
    endproperty
    a_dark: assert property (p_dark) else $error("indicator lit without power");
    property p_short;
        (control_power && !int_fail_pin && short_pin != 8'h00) [*6] |-> led_red && !led_green;
    endproperty
    a_short: assert property (p_short) else $error("short not steady red");
    property p_fail;
        (control_power && int_fail_pin) [*8] |-> led_red != led_green;
    endproperty
    a_fail: assert property (p_fail) else $error("failure not alternating");
    property p_off;
        (control_power && !int_fail_pin && conn_pin4 == 4'h0 && conn_pin2 == 4'h0) [*6]
            |-> !led_green;
    endproperty
    a_off: assert property (p_off) else $error("green with outputs off");
    c_img: cover property (img_wr);
    c_flash: cover property (led_red ##1 !led_red && !led_green);
    c_alt: cover property (led_red ##[1:8] led_green);
endmodule : dout_unit_chk

bind dout_unit dout_unit_chk #(.FLASH_HALF(FLASH_HALF)) i_chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .control_power(control_power), .short_pin(short_pin), .int_fail_pin(int_fail_pin),
    .conn_pin4(conn_pin4), .conn_pin2(conn_pin2), .led_red(led_red), .led_green(led_green)
);

/* File: dout_load_model.sv */
// output load model: short and open sense from commanded faults
// assumes the connector pin outputs of dout_unit
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dout_load_model (
    input  wire logic [3:0] conn_pin4,
    input  wire logic [3:0] conn_pin2,
    input  wire logic [7:0] short_cmd,
    input  wire logic [7:0] open_cmd,
    output logic      [7:0] short_pin,
    output logic      [7:0] open_pin
);
    logic [7:0] drive;
    // undo the connector mapping to get per-channel drive
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            drive[2*n]   = conn_pin4[n];
            drive[2*n+1] = conn_pin2[n];
        end
    end
    // a shorted load only draws overcurrent while its channel is on
    assign short_pin = short_cmd & drive;
    assign open_pin  = open_cmd;
endmodule : dout_load_model

/* File: dout_unit_tb_top.sv */
// testbench for dout_unit: bus tasks, load model, indicator sampling
// assumes dout_pkg, dout_load_model and the bound checker
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dout_unit_tb_top;
    import dout_pkg::*;
    localparam int FH = 4;
    logic        clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, term_ol_wr = 0;
    logic        control_power = 0, int_fail_pin = 0, led_red, led_green, irq;
    logic [3:0]  reg_addr = 4'h0, conn_pin4, conn_pin2;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [7:0]  term_ol_data = 8'h00, short_cmd = 8'h00, open_cmd = 8'h00;
    logic [7:0]  short_pin, open_pin;
    int          err_count = 0, checks = 0, rc, gc;
    always #4 clk = ~clk;
    dout_unit #(.FLASH_HALF(FH)) i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .term_ol_wr(term_ol_wr), .term_ol_data(term_ol_data), .control_power(control_power),
        .short_pin(short_pin), .open_pin(open_pin), .int_fail_pin(int_fail_pin),
        .conn_pin4(conn_pin4), .conn_pin2(conn_pin2), .led_red(led_red),
        .led_green(led_green), .irq(irq));
    dout_load_model i_load (.conn_pin4(conn_pin4), .conn_pin2(conn_pin2),
        .short_cmd(short_cmd), .open_cmd(open_cmd), .short_pin(short_pin), .open_pin(open_pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask : rd
    // settle the sync and indicator pipeline, then count over two flash periods
    task automatic led(input int er, input int eg);
        rc = 0;
        gc = 0;
        repeat (8) @(posedge clk);
        repeat (4 * FH) begin
            @(negedge clk);
            rc += int'(led_red);
            gc += int'(led_green);
        end
        chk(rc, er);
        chk(gc, eg);
        @(posedge clk);
    endtask : led
    task automatic results;
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn        <= 1'b1;
        control_power <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_CNT_LIMIT, CNT_LIMIT_RESET);
        rd(4'h9, 32'h0);
        // walk a single one over the image, checking both pins of each connector
        for (int i = 0; i < 8; i++) begin
            wr(REG_OUT_IMAGE, 32'h1 << i);
            @(negedge clk);
            @(negedge clk);
            chk({conn_pin2, conn_pin4}, (i % 2 == 0) ? (1 << (i / 2)) : (16 << (i / 2)));
        end
        led(0, 4 * FH);
        wr(REG_OUT_IMAGE, 32'h0);
        led(0, 0);
        wr(REG_OUT_IMAGE, 32'h1);
        control_power <= 1'b0;
        led(0, 0);
        control_power <= 1'b1;
        short_cmd     <= 8'h01;
        led(4 * FH, 0);
        rd(REG_SHORT, 32'h1);
        rd(REG_STATUS, 32'h1 << ST_SHORT);
        chk(irq, 32'h0);
        wr(REG_MASK, 32'h1 << ST_SHORT);
        @(negedge clk);
        chk(irq, 32'h1);
        rd(REG_MASK, 32'h1 << ST_SHORT);
        rd(REG_OUT_IMAGE, 32'h1);
        @(posedge clk);
        short_cmd <= 8'h00;
        led(0, 4 * FH);
        wr(REG_STATUS, 32'hF);
        @(negedge clk);
        chk(irq, 32'h0);
        // bus writes to the open-load enable are refused, the terminal is not
        wr(REG_OL_ENABLE, 32'hFF);
        rd(REG_OL_ENABLE, 32'h0);
        @(posedge clk);
        term_ol_wr   <= 1'b1;
        term_ol_data <= 8'hFF;
        @(posedge clk);
        term_ol_wr <= 1'b0;
        rd(REG_OL_ENABLE, 32'hFF);
        @(posedge clk);
        open_cmd <= 8'h03;
        led(2 * FH, 0);
        rd(REG_OPEN_LOAD, 32'h2);
        rd(REG_STATUS, 32'h1 << ST_OPEN_LOAD);
        @(posedge clk);
        open_cmd     <= 8'h00;
        short_cmd    <= 8'h01;
        int_fail_pin <= 1'b1;
        led(2 * FH, 2 * FH);
        short_cmd    <= 8'h00;
        int_fail_pin <= 1'b0;
        // channel 6 rose once in the walk; two more rises pass a limit of two
        wr(REG_CNT_LIMIT, 32'h2);
        wr(REG_OUT_IMAGE, 32'h40);
        wr(REG_OUT_IMAGE, 32'h0);
        rd(REG_EXCEEDED, 32'h0);
        wr(REG_OUT_IMAGE, 32'h40);
        wr(REG_OUT_IMAGE, 32'h0);
        rd(REG_EXCEEDED, 32'h40);
        led(2 * FH, 0);
        results();
    end
endmodule : dout_unit_tb_top
